// ===== hdl/gptc_defs.svh
/*
  Offsets, field positions, reset values and mode codes of the timer.
  Assumes a 32-bit APB slave with byte addresses on an 8-bit offset.
*/
`ifndef GPTC_DEFS_SVH
`define GPTC_DEFS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define GPTC_OFF_CTRL    8'h00
`define GPTC_OFF_CMD     8'h04
`define GPTC_OFF_INIT    8'h08
`define GPTC_OFF_DELAY   8'h0C
`define GPTC_OFF_WIDTH   8'h10
`define GPTC_OFF_COUNT   8'h14
`define GPTC_OFF_STATUS  8'h18

// ************************************************************
// Control fields
// ************************************************************
`define GPTC_CTRL_MODE_LSB  0
`define GPTC_CTRL_MODE_MSB  3
`define GPTC_CTRL_CLK_POL   4
`define GPTC_CTRL_GATE_POL  5
`define GPTC_CTRL_OUT_POL   6
`define GPTC_CTRL_TB_INT    7
`define GPTC_CTRL_RST_VAL   32'h0000_0003

// ************************************************************
// Command and status bits
// ************************************************************
`define GPTC_CMD_START      0
`define GPTC_CMD_RESET      1
`define GPTC_STAT_DONE      0
`define GPTC_STAT_BUSY      1
`define GPTC_STAT_OUT       2

// ************************************************************
// Mode codes
// ************************************************************
`define GPTC_MODE_PW_MEAS   4'h3
`define GPTC_MODE_GATED_1   4'h4
`define GPTC_MODE_TRIG_1    4'h5
`define GPTC_MODE_RETRIG    4'h6
`define GPTC_MODE_TRIG_CONT 4'h7
`define GPTC_MODE_GATED_CON 4'h8
`define GPTC_MODE_EDGE_SEP  4'h9
`define GPTC_MODE_PWM       4'hA

`endif

// ===== hdl/gptc_pkg.sv
/*
  Types shared by the timer/counter design.
  Assumes the constants of gptc_defs.svh for codes and offsets.
*/
package gptc_pkg;

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    GPTC_IDLE,
    GPTC_ARMED,
    GPTC_MEASURE,
    GPTC_DELAY,
    GPTC_PULSE,
    GPTC_DONE
  } gptc_state_t;

endpackage

// ===== hdl/gptc_timer.sv
/*
  General-purpose 32-bit timer/counter, modes 3 to 10, with APB registers.
  Assumes one 10 MHz clock; pins arrive asynchronous and are synchronised.
*/
`timescale 1ns/1ps
`include "gptc_defs.svh"

module gptc_timer
  import gptc_pkg::*;
#(
  parameter int CNT_W = 32        // Counter width
) (
  input  wire logic        ref_clk_i,          // 10 MHz system clock
  input  wire logic        reset_i,            // Synchronous, active high
  input  wire logic        psel_i,             // APB select
  input  wire logic        penable_i,          // APB access phase
  input  wire logic        pwrite_i,           // APB direction
  input  wire logic [7:0]  paddr_i,            // APB byte address
  input  wire logic [31:0] pwdata_i,           // APB write data
  output logic      [31:0] prdata_o,           // APB read data
  output logic             pready_o,           // APB ready
  output logic             pslverr_o,          // APB error, unmapped
  input  wire logic        count_clock_in_i,   // Counting clock pin
  input  wire logic        gate_in_i,          // Gate pin
  input  wire logic        direction_in_i,     // Up/down pin
  input  wire logic        second_edge_in_i,   // Auxiliary pin
  output logic             pulse_out_o         // Pulse output pin
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [31:0]      ctrl;          // Mode, polarities, timebase
  logic [CNT_W-1:0] init_val;      // Preloaded start value
  logic [CNT_W-1:0] delay_val;     // Delay, interval or initial phase
  logic [CNT_W-1:0] width_val;     // Width or active phase
  logic [CNT_W-1:0] count;         // Measurement counter
  logic [CNT_W-1:0] phase_cnt;     // Pulse phase counter
  logic             done;          // Measurement or pulse finished
  logic             gate_seen;     // Mode 3 gate became active
  logic             out_level;     // Output before polarity
  gptc_state_t      state;         // Sequencer state
  logic [3:0]       sync1;         // First synchroniser stage
  logic [3:0]       sync2;         // Second synchroniser stage
  logic [3:0]       sync3;         // Third synchroniser stage
  logic [3:0]       filt;          // Settled pin levels
  logic [3:0]       filt_d;        // Settled levels one cycle back
  logic [3:0]       mode;          // Selected mode
  logic             clk_edge;      // Active counting clock edge
  logic             gate_act;      // Gate in active state
  logic             gate_edge;     // Active gate edge
  logic             aux_rise;      // Rising edge on auxiliary pin
  logic             count_up;      // Direction from pin
  logic             tick;          // One timebase period elapsed
  logic             gated;         // Mode freezes with gate
  logic             adv;           // Phase counter may advance
  logic             continuous;    // Mode repeats its pulses
  logic             wr_en;         // APB write in access phase
  logic             rd_setup;      // APB read in setup phase
  logic             mapped;        // Address hits a register
  logic             start_cmd;     // Software start strobe
  logic             reset_cmd;     // Software reset strobe
  logic [31:0]      next_rdata;    // Read mux output

  // ************************************************************
  // Pin synchronisers
  // ************************************************************

  // Three stages per pin; level moves once stages two and three agree
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end else begin
      sync1 <= {second_edge_in_i, direction_in_i, gate_in_i, count_clock_in_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Settled levels and their previous values for edge finding
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      filt   <= 4'h0;
      filt_d <= 4'h0;
    end else begin
      filt   <= ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
      filt_d <= filt;
    end
  end

  // ************************************************************
  // Pin decode
  // ************************************************************
  assign mode = ctrl[`GPTC_CTRL_MODE_MSB:`GPTC_CTRL_MODE_LSB];

  assign clk_edge  = (filt[0] ^ ctrl[`GPTC_CTRL_CLK_POL]) &
                     ~(filt_d[0] ^ ctrl[`GPTC_CTRL_CLK_POL]);
  assign gate_act  = filt[1] ^ ctrl[`GPTC_CTRL_GATE_POL];
  assign gate_edge = gate_act & ~(filt_d[1] ^ ctrl[`GPTC_CTRL_GATE_POL]);
  assign aux_rise  = filt[3] & ~filt_d[3];

  assign count_up = filt[2];

  assign tick = ctrl[`GPTC_CTRL_TB_INT] ? 1'b1 : clk_edge;

  // gate freezes modes 4 and 8
  assign gated = (mode == `GPTC_MODE_GATED_1) || (mode == `GPTC_MODE_GATED_CON);
  assign adv   = tick & (~gated | gate_act);

  // Modes that run pulses without end
  assign continuous = (mode == `GPTC_MODE_TRIG_CONT) ||
                      (mode == `GPTC_MODE_GATED_CON) || (mode == `GPTC_MODE_PWM);

  // ************************************************************
  // APB slave
  // ************************************************************
  assign wr_en     = psel_i & penable_i & pwrite_i;
  assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;
  assign start_cmd = wr_en & (paddr_i == `GPTC_OFF_CMD) & pwdata_i[`GPTC_CMD_START];
  assign reset_cmd = wr_en & (paddr_i == `GPTC_OFF_CMD) & pwdata_i[`GPTC_CMD_RESET];
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // Address decode of the register map
  always_comb begin
    mapped     = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (paddr_i)
      `GPTC_OFF_CTRL:   next_rdata = ctrl;
      `GPTC_OFF_CMD:    next_rdata = 32'h0000_0000;
      `GPTC_OFF_INIT:   next_rdata = 32'(init_val);
      `GPTC_OFF_DELAY:  next_rdata = 32'(delay_val);
      `GPTC_OFF_WIDTH:  next_rdata = 32'(width_val);
      `GPTC_OFF_COUNT:  next_rdata = 32'(count);
      `GPTC_OFF_STATUS: next_rdata = {29'h0000_0000, pulse_out_o,
                                      (state != GPTC_IDLE) && (state != GPTC_DONE),
                                      done};
      default:          mapped = 1'b0;
    endcase
  end

  // Read data captured in the setup phase, held through access
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_o <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl      <= `GPTC_CTRL_RST_VAL;
      init_val  <= '0;
      delay_val <= '0;
      width_val <= '0;
    end else if (wr_en) begin
      if (paddr_i == `GPTC_OFF_CTRL) begin
        ctrl <= {24'h00_0000, pwdata_i[7:0]};
      end
      if (paddr_i == `GPTC_OFF_INIT) begin
        init_val <= pwdata_i[CNT_W-1:0];
      end
      if (paddr_i == `GPTC_OFF_DELAY) begin
        delay_val <= pwdata_i[CNT_W-1:0];
      end
      if (paddr_i == `GPTC_OFF_WIDTH) begin
        width_val <= pwdata_i[CNT_W-1:0];
      end
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************

  // Mode sequencing of delays, pulses and measurements
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || reset_cmd) begin
      state     <= GPTC_IDLE;
      phase_cnt <= '0;
      gate_seen <= 1'b0;
    end else if (start_cmd) begin
      gate_seen <= 1'b0;
      phase_cnt <= delay_val;
      unique case (mode)
        `GPTC_MODE_PW_MEAS:  state <= GPTC_MEASURE;
        `GPTC_MODE_TRIG_1,
        `GPTC_MODE_RETRIG,
        `GPTC_MODE_TRIG_CONT,
        `GPTC_MODE_EDGE_SEP: state <= GPTC_ARMED;
        `GPTC_MODE_GATED_1,
        `GPTC_MODE_GATED_CON,
        `GPTC_MODE_PWM:      state <= GPTC_DELAY;
        default:             state <= GPTC_IDLE;
      endcase
    end else begin
      unique case (state)
        GPTC_IDLE: begin
          // Halted until software start
        end
        GPTC_ARMED: begin
          if (mode == `GPTC_MODE_EDGE_SEP) begin
            if (gate_edge) begin
              state <= GPTC_MEASURE;
            end
          end else if (gate_edge) begin
            state     <= GPTC_DELAY;
            phase_cnt <= delay_val;
          end
        end
        GPTC_MEASURE: begin
          if (mode == `GPTC_MODE_PW_MEAS) begin
            if (gate_act) begin
              gate_seen <= 1'b1;
            end else if (gate_seen) begin
              state <= GPTC_DONE;
            end
          end else if (aux_rise) begin
            state <= GPTC_DONE;
          end
        end
        GPTC_DELAY: begin
          if (adv) begin
            // Last period of the phase hands over, so N periods exactly
            if (phase_cnt[CNT_W-1:1] == '0) begin
              state     <= GPTC_PULSE;
              phase_cnt <= width_val;
            end else begin
              phase_cnt <= phase_cnt - 1'b1;
            end
          end
        end
        GPTC_PULSE: begin
          if (adv) begin
            if (phase_cnt[CNT_W-1:1] == '0) begin
              phase_cnt <= delay_val;
              if (continuous) begin
                state <= GPTC_DELAY;
              end else if (mode == `GPTC_MODE_RETRIG) begin
                state <= GPTC_ARMED;
              end else begin
                state <= GPTC_DONE;
              end
            end else begin
              phase_cnt <= phase_cnt - 1'b1;
            end
          end
        end
        GPTC_DONE: begin
          // Finished until start or reset
        end
        default: state <= GPTC_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Measurement counter
  // ************************************************************

  // Count loads the preload on start or software reset, then steps per tick in the measure state, in mode 3 only while the gate is active
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      count <= '0;
    end else if (reset_cmd || start_cmd) begin
      count <= init_val;
    end else if (state == GPTC_MEASURE && tick) begin
      if ((mode == `GPTC_MODE_EDGE_SEP) || gate_act) begin
        count <= count_up ? count + 1'b1 : count - 1'b1;
      end
    end
  end

  // ************************************************************
  // Status and output
  // ************************************************************

  // Done flag: set by finish wins over a start or software-reset clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      done <= 1'b0;
    end else if ((state == GPTC_DONE) && !done) begin
      // Set only on reaching done, so a later start can clear it
      done <= 1'b1;
    end else if (reset_cmd || start_cmd) begin
      done <= 1'b0;
    end
  end

  // Output level ahead of polarity
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || reset_cmd) begin
      out_level <= 1'b0;
    end else if (start_cmd) begin
      out_level <= 1'b0;
    end else begin
      out_level <= (state == GPTC_PULSE) ||
                   ((state == GPTC_DONE) && ((mode == `GPTC_MODE_PW_MEAS) ||
                                             (mode == `GPTC_MODE_EDGE_SEP)));
    end
  end

  assign pulse_out_o = out_level ^ ctrl[`GPTC_CTRL_OUT_POL];

endmodule

// ===== dv/gptc_timer_checker.sv
/*
  Assertions on the bus face and reset state of the timer.
  Assumes it is bound onto gptc_timer and sees only its ports.
*/
`timescale 1ns/1ps
`include "gptc_defs.svh"

module gptc_timer_checker (
  input  wire logic        ref_clk_i,   // System clock
  input  wire logic        reset_i,     // Synchronous reset
  input  wire logic        psel_i,      // Bus select
  input  wire logic        penable_i,   // Bus access phase
  input  wire logic        pwrite_i,    // Bus direction
  input  wire logic [7:0]  paddr_i,     // Bus address
  input  wire logic [31:0] pwdata_i,    // Bus write data
  input  wire logic [31:0] prdata_o,    // Bus read data
  input  wire logic        pready_o,    // Bus ready
  input  wire logic        pslverr_o,   // Bus error
  input  wire logic        pulse_out_o  // Pulse pin
);
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  logic        mapped;   // Address hits a register
  logic        acc;      // Access phase
  logic [7:0]  ctrl_sh;  // Last control byte written
  logic [31:0] init_sh;  // Last preload written
  logic        init_ok;  // Preload written since reset

  assign mapped = (paddr_i <= `GPTC_OFF_STATUS) && (paddr_i[1:0] == 2'b00);
  assign acc    = psel_i && penable_i;

  // Shadow of the control byte and the preload-written flag
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl_sh <= 8'(`GPTC_CTRL_RST_VAL);
      init_ok <= 1'b0;
    end else if (acc && pwrite_i && paddr_i == `GPTC_OFF_CTRL) begin
      ctrl_sh <= pwdata_i[7:0];
    end else if (acc && pwrite_i && paddr_i == `GPTC_OFF_INIT) begin
      init_ok <= 1'b1;
    end
  end

  // Preload value as last written
  always_ff @(posedge ref_clk_i) begin
    if (acc && pwrite_i && paddr_i == `GPTC_OFF_INIT) begin
      init_sh <= pwdata_i;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_ready_high: assert property (pready_o)
    else $error("ready low");
  a_slverr_map: assert property (pslverr_o == (acc && !mapped))
    else $error("error flag does not match the address map");
  a_unmapped_zero: assert property (acc && !pwrite_i && !mapped |-> prdata_o == 32'h0)
    else $error("unmapped read returns data");
  a_rdata_hold: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
    else $error("read data moved outside a read setup");
  a_ctrl_readback: assert property (
    acc && !pwrite_i && paddr_i == `GPTC_OFF_CTRL |-> prdata_o[7:0] == ctrl_sh)
    else $error("control readback differs");
  a_init_readback: assert property (
    acc && !pwrite_i && paddr_i == `GPTC_OFF_INIT && init_ok |-> prdata_o == init_sh)
    else $error("preload readback differs");
  a_reset_out: assert property ($fell(reset_i) |-> !pulse_out_o)
    else $error("pulse pin active after reset");
  a_reset_rdata: assert property ($fell(reset_i) |-> prdata_o == 32'h0)
    else $error("read data not cleared by reset");
endmodule

bind gptc_timer gptc_timer_checker u_chk (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .pulse_out_o(pulse_out_o)
);

// ===== dv/gptc_pin_model.sv
/*
  External pin sources for the timer: counting clock, gate, direction, aux.
  Assumes the bench reference clock; pins change just after its rising edge.
*/
`timescale 1ns/1ps

module gptc_pin_model (
  input  wire logic ref_clk_i,         // Bench reference clock
  output logic      count_clock_in_o,  // Counting clock, still outside bursts
  output logic      gate_in_o,         // Gate level
  output logic      direction_in_o,    // High counts up
  output logic      second_edge_in_o   // Auxiliary edge source
);
  // Quiet pins at time zero
  initial begin
    count_clock_in_o = 1'b0;
    gate_in_o        = 1'b0;
    direction_in_o   = 1'b1;
    second_edge_in_o = 1'b0;
  end

  // Set gate, direction and aux levels after the next edge
  task automatic set_pins(input logic g, input logic d, input logic a);
    @(posedge ref_clk_i);
    gate_in_o        <= g;
    direction_in_o   <= d;
    second_edge_in_o <= a;
  endtask

  // Burst of n clock periods; each level spans several ref cycles
  task automatic clk_burst(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      count_clock_in_o <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      count_clock_in_o <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
    end
  endtask

  // One gate pulse, three cycles high and two low
  task automatic gate_pulse();
    @(posedge ref_clk_i);
    gate_in_o <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    gate_in_o <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask
endmodule

// ===== dv/gp_timer_counter_modes_test.sv
/*
  Self-checking bench for the timer/counter in modes 3 to 10.
  Assumes gptc_timer, its checker bind and the pin model are compiled first.
*/
`timescale 1ns/1ps
`include "gptc_defs.svh"

module gp_timer_counter_modes_test;
  logic        ref_clk_i, reset_i;           // Clock and reset
  logic        psel_i, penable_i, pwrite_i;  // Bus control
  logic [7:0]  paddr_i;                      // Bus address
  logic [31:0] pwdata_i, prdata_o;           // Bus data
  logic        pready_o, pslverr_o, serr;    // Bus answer, last error seen
  logic        clk_pin, gate_pin, dir_pin;   // Pins from the model
  logic        aux_pin, pulse_out_o, out_q;  // Aux pin, output, last output
  int          failures, checked;            // Report counters
  int          rises, hi_len, per_len, cyc, t_rise; // Output monitor

  // Free-running 10 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  gptc_timer uut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .count_clock_in_i(clk_pin),
    .gate_in_i(gate_pin), .direction_in_i(dir_pin), .second_edge_in_i(aux_pin),
    .pulse_out_o(pulse_out_o)
  );
  gptc_pin_model fab (
    .ref_clk_i(ref_clk_i), .count_clock_in_o(clk_pin), .gate_in_o(gate_pin),
    .direction_in_o(dir_pin), .second_edge_in_o(aux_pin)
  );

  // Counts output rises, high time and rise-to-rise period
  always @(posedge ref_clk_i) begin
    cyc++;
    if (pulse_out_o === 1'b1 && out_q === 1'b0) begin
      rises++;
      per_len = cyc - t_rise;
      t_rise  = cyc;
    end
    if (pulse_out_o === 1'b0 && out_q === 1'b1) begin
      hi_len = cyc - t_rise;
    end
    out_q = pulse_out_o;
  end

  // One bus transfer; holds the request until ready, then releases
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    serr = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask

  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Control reset value, preload read/write and an unmapped place
  task automatic t_regs();
    logic [31:0] q;
    rd(`GPTC_OFF_CTRL, q);
    chk("ctrl_reset", `GPTC_CTRL_RST_VAL, q);
    wr(`GPTC_OFF_INIT, 32'hA5A5_0001);
    rd(`GPTC_OFF_INIT, q);
    chk("init_rw", 32'hA5A5_0001, q);
    rd(8'h40, q);
    chk("unmapped_err", 32'h1, {31'h0, serr});
    chk("unmapped_data", 32'h0, q);
  endtask

  // Pulse width from preload 5, clocks outside the gate ignored
  task automatic t_mode3();
    logic [31:0] q;
    wr(`GPTC_OFF_CTRL, 32'h0000_0003);
    wr(`GPTC_OFF_INIT, 32'h0000_0005);
    wr(`GPTC_OFF_CMD, 32'h0000_0001);
    fab.clk_burst(2);
    fab.set_pins(1'b1, 1'b1, 1'b0);
    repeat (8) @(posedge ref_clk_i);
    fab.clk_burst(6);
    fab.set_pins(1'b0, 1'b1, 1'b0);
    fab.clk_burst(2);
    repeat (8) @(posedge ref_clk_i);
    rd(`GPTC_OFF_COUNT, q);
    chk("width_count", 32'h0000_000B, q);
    chk("done_pin", 32'h1, {31'h0, pulse_out_o});
    rd(`GPTC_OFF_STATUS, q);
    chk("done_flag", 32'h1, {31'h0, q[`GPTC_STAT_DONE]});
  endtask

  // Gate rise to aux rise, counting down through zero
  task automatic t_mode9();
    logic [31:0] q;
    wr(`GPTC_OFF_CTRL, 32'h0000_0009);
    wr(`GPTC_OFF_INIT, 32'h0000_0002);
    fab.set_pins(1'b0, 1'b0, 1'b0);
    wr(`GPTC_OFF_CMD, 32'h0000_0001);
    fab.set_pins(1'b1, 1'b0, 1'b0);
    repeat (8) @(posedge ref_clk_i);
    fab.clk_burst(4);
    fab.set_pins(1'b1, 1'b0, 1'b1);
    fab.clk_burst(2);
    repeat (8) @(posedge ref_clk_i);
    rd(`GPTC_OFF_COUNT, q);
    chk("sep_count", 32'hFFFF_FFFE, q);
    fab.set_pins(1'b0, 1'b1, 1'b0);
  endtask

  // Wave on the internal timebase, inverted output, then soft reset
  task automatic t_pwm();
    logic [31:0] q;
    wr(`GPTC_OFF_CTRL, 32'h0000_008A);
    wr(`GPTC_OFF_DELAY, 32'h0000_0003);
    wr(`GPTC_OFF_WIDTH, 32'h0000_0005);
    wr(`GPTC_OFF_CMD, 32'h0000_0001);
    repeat (60) @(posedge ref_clk_i);
    chk("pwm_high", 32'h5, 32'(hi_len));
    chk("pwm_period", 32'h8, 32'(per_len));
    wr(`GPTC_OFF_CTRL, 32'h0000_00CA);
    repeat (40) @(posedge ref_clk_i);
    chk("pwm_inv_high", 32'h3, 32'(hi_len));
    wr(`GPTC_OFF_INIT, 32'h0000_0007);
    wr(`GPTC_OFF_CMD, 32'h0000_0002);
    repeat (3) @(posedge ref_clk_i);
    rises = 0;
    repeat (40) @(posedge ref_clk_i);
    chk("halted", 32'h0, 32'(rises));
    chk("idle_level", 32'h1, {31'h0, pulse_out_o});
    rd(`GPTC_OFF_COUNT, q);
    chk("reload", 32'h0000_0007, q);
  endtask

  // Active-low gate and falling count clock edges pace a mode 4 pulse
  task automatic t_pol();
    wr(`GPTC_OFF_CMD, 32'h0000_0002);
    fab.set_pins(1'b0, 1'b1, 1'b0);
    wr(`GPTC_OFF_CTRL, 32'h0000_0034);
    repeat (6) @(posedge ref_clk_i);
    rises = 0;
    wr(`GPTC_OFF_CMD, 32'h0000_0001);
    fab.clk_burst(8);
    repeat (8) @(posedge ref_clk_i);
    chk("pol_pulses", 32'h1, 32'(rises));
    chk("ext_width", 32'h18, 32'(hi_len));
  endtask

  // Pulse modes with delay 2, width 4 and n gate pulses; e below 0 means at least -e
  task automatic pulse_mode(input logic [3:0] m, input logic g, input int n,
                            input int gap, input int e);
    wr(`GPTC_OFF_CMD, 32'h0000_0002);
    fab.set_pins(g, 1'b1, 1'b0);
    wr(`GPTC_OFF_CTRL, {24'h0, 4'h8, m});
    wr(`GPTC_OFF_DELAY, 32'h0000_0002);
    wr(`GPTC_OFF_WIDTH, 32'h0000_0004);
    repeat (6) @(posedge ref_clk_i);
    rises = 0;
    wr(`GPTC_OFF_CMD, 32'h0000_0001);
    repeat (n) begin
      repeat (gap) @(posedge ref_clk_i);
      fab.gate_pulse();
    end
    repeat (60) @(posedge ref_clk_i);
    if (e < 0) begin
      chk("pulse_min", 32'h1, {31'h0, rises >= -e});
    end else begin
      chk("pulses", 32'(e), 32'(rises));
    end
    if (m == `GPTC_MODE_GATED_1 && e == 1) begin
      chk("width", 32'h4, 32'(hi_len));
    end
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    failures++;
    summarize();
  end

  // Main sequence
  initial begin
    reset_i   = 1'b1;
    psel_i    = 1'b0;
    penable_i = 1'b0;
    pwrite_i  = 1'b0;
    paddr_i   = 8'h00;
    pwdata_i  = 32'h0;
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    t_regs();
    t_mode3();
    t_mode9();
    t_pwm();
    pulse_mode(4'h4, 1'b1, 0, 0, 1);
    pulse_mode(4'h4, 1'b0, 0, 0, 0);
    pulse_mode(4'h5, 1'b0, 2, 30, 1);
    pulse_mode(4'h6, 1'b0, 2, 30, 2);
    pulse_mode(4'h6, 1'b0, 2, 0, 1);
    pulse_mode(4'h7, 1'b0, 2, 30, -5);
    pulse_mode(4'h8, 1'b0, 0, 0, 0);
    pulse_mode(4'h8, 1'b1, 0, 0, -3);
    t_pol();
    summarize();
  end
endmodule
